// ==== src/pas_consts.vh ====
// Register offsets, field layouts and reset values of the analog select and pull-up block
`ifndef PAS_CONSTS_VH
`define PAS_CONSTS_VH
`define PAS_ADDR_W          4
`define PAS_OFF_SEL_LOW     4'h0
`define PAS_OFF_SEL_HIGH    4'h1
`define PAS_OFF_PULLUP      4'h2
`define PAS_OFF_DIR         4'h3
`define PAS_OFF_PORT_OUT    4'h4
`define PAS_OFF_PORT_IN     4'h5
`define PAS_OFF_PIN_STAT    4'h6
`define PAS_SEL_LOW_RST     8'hFF
`define PAS_SEL_HIGH_RST    4'hF
`define PAS_SEL_HIGH_W      4
`define PAS_PULLUP_RST      8'h37
`define PAS_PULLUP_MASK     8'h37
`define PAS_DIR_RST         8'hFF
`define PAS_PORT_OUT_RST    8'h00
`define PAS_ZERO8           8'h00
`define PAS_ZERO4           4'h0
`endif

// ==== src/pas_pin_cell.v ====
// One pin's gating of digital input, pull-up and change detect by analog select
module pas_pin_cell (
   input  wire clk,
   input  wire rst_b,
   input  wire clk_en,
   input  wire pin_raw,
   input  wire analog_select,
   input  wire direction_bit,
   input  wire pullup_en,
   input  wire has_pullup,
   output wire dig_in,
   output wire pullup_on,
   output wire ioc_allow
);
   reg sync1_q;
   reg sync2_q;

   // Two flops: pin is asynchronous to clk
   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end
      else if (clk_en)
      begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   // Input buffer off when analog, so reads see zero
   assign dig_in    = sync2_q & ~analog_select;
   // Pull-up needs input mode and digital mode
   assign pullup_on = has_pullup & pullup_en & direction_bit & ~analog_select;
   assign ioc_allow = ~analog_select;
endmodule

// ==== src/pas_top.v ====
// Register file and per-pin analog select, pull-up and input gating
//
// Our own choices: the register offsets and strobed register access.
`include "pas_consts.vh"

module pas_top #(
   parameter N_PINS = 12
) (
   input  wire                     clk,
   input  wire                     rst_b,
   input  wire                     clk_en,
   input  wire [`PAS_ADDR_W-1:0]   addr,
   input  wire [7:0]               wdata,
   input  wire                     wr_stb,
   input  wire                     rd_stb,
   output reg  [7:0]               rdata,
   input  wire [N_PINS-1:0]        pin_in,
   output reg  [N_PINS-1:0]        pin_out,
   output reg  [N_PINS-1:0]        pin_oe,
   output reg  [N_PINS-1:0]        pullup_on,
   output reg  [N_PINS-1:0]        ioc_allow,
   output reg  [N_PINS-1:0]        analog_sel
);
   reg  [7:0]                 sel_low_q;
   reg  [`PAS_SEL_HIGH_W-1:0] sel_high_q;
   reg  [7:0]                 pullup_q;
   reg  [7:0]                 dir_low_q;
   reg  [7:0]                 dir_high_q;
   reg  [7:0]                 out_low_q;
   reg  [7:0]                 out_high_q;
   reg  [7:0]                 rdata_d;
   wire [15:0]                sel_all;
   wire [15:0]                dir_all;
   wire [15:0]                out_all;
   wire [15:0]                pu_all;
   wire [N_PINS-1:0]          dig_in;
   wire [N_PINS-1:0]          pu_w;
   wire [N_PINS-1:0]          ioc_w;
   wire [15:0]                dig_in16;

   assign sel_all  = {`PAS_ZERO4, sel_high_q, sel_low_q};
   assign dir_all  = {dir_high_q, dir_low_q};
   assign out_all  = {out_high_q, out_low_q};
   // Only port A pins 0-2 and 4-5 map to the pull-up register (mask 8'h37)
   assign pu_all   = {`PAS_ZERO8, pullup_q & `PAS_PULLUP_MASK};
   assign dig_in16 = {{(16 - N_PINS){1'b0}}, dig_in};

   genvar g;
   generate
      for (g = 0; g < N_PINS; g = g + 1)
      begin : pin
         pas_pin_cell u_cell (
            .clk           (clk),
            .rst_b         (rst_b),
            .clk_en        (clk_en),
            .pin_raw       (pin_in[g]),
            .analog_select (sel_all[g]),
            .direction_bit (dir_all[g]),
            .pullup_en     (pu_all[g]),
            .has_pullup    (g < 8),
            .dig_in        (dig_in[g]),
            .pullup_on     (pu_w[g]),
            .ioc_allow     (ioc_w[g])
         );
      end
   endgenerate

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         sel_low_q  <= `PAS_SEL_LOW_RST;
         sel_high_q <= `PAS_SEL_HIGH_RST;
         pullup_q   <= `PAS_PULLUP_RST;
         dir_low_q  <= `PAS_DIR_RST;
         dir_high_q <= `PAS_DIR_RST;
         out_low_q  <= `PAS_PORT_OUT_RST;
         out_high_q <= `PAS_PORT_OUT_RST;
      end
      else if (clk_en && wr_stb)
      begin
         case (addr)
            `PAS_OFF_SEL_LOW:  sel_low_q  <= wdata;
            `PAS_OFF_SEL_HIGH: sel_high_q <= wdata[`PAS_SEL_HIGH_W-1:0];
            `PAS_OFF_PULLUP:   pullup_q   <= wdata & `PAS_PULLUP_MASK;
            `PAS_OFF_DIR:      dir_low_q  <= wdata;
            `PAS_OFF_PORT_OUT: out_low_q  <= wdata;
            default:           ;
         endcase
      end
   end

   // Pins 8-11 have no writable direction or output register here; they keep their reset values
   always @*
   begin
      case (addr)
         `PAS_OFF_SEL_LOW:  rdata_d = sel_low_q;
         `PAS_OFF_SEL_HIGH: rdata_d = {`PAS_ZERO4, sel_high_q};
         `PAS_OFF_PULLUP:   rdata_d = pullup_q;
         `PAS_OFF_DIR:      rdata_d = dir_low_q;
         `PAS_OFF_PORT_OUT: rdata_d = out_low_q;
         `PAS_OFF_PORT_IN:  rdata_d = dig_in16[7:0];
         `PAS_OFF_PIN_STAT: rdata_d = dig_in16[15:8];
         default:           rdata_d = `PAS_ZERO8;
      endcase
   end

   always @(posedge clk)
   begin
      if (!rst_b)
      begin
         rdata      <= `PAS_ZERO8;
         pin_out    <= {N_PINS{1'b0}};
         pin_oe     <= {N_PINS{1'b0}};
         pullup_on  <= {N_PINS{1'b0}};
         ioc_allow  <= {N_PINS{1'b0}};
         analog_sel <= {N_PINS{1'b1}};
      end
      else if (clk_en)
      begin
         if (rd_stb)
            rdata <= rdata_d;
         // Driver obeys direction only, analog or not; software must pick input first
         pin_out    <= out_all[N_PINS-1:0];
         pin_oe     <= ~dir_all[N_PINS-1:0];
         pullup_on  <= pu_w;
         ioc_allow  <= ioc_w;
         analog_sel <= sel_all[N_PINS-1:0];
      end
   end
endmodule

// ==== test/pas_top_assertions.sv ====
// Assertions on select, pull-up and read gating
module pas_chk #(parameter N_PINS = 12) (
   input logic              clk,
   input logic              rst_b,
   input logic              clk_en,
   input logic [3:0]        addr,
   input logic [7:0]        wdata,
   input logic              wr_stb,
   input logic              rd_stb,
   input logic [7:0]        rdata,
   input logic [N_PINS-1:0] pin_oe,
   input logic [N_PINS-1:0] pullup_on,
   input logic [N_PINS-1:0] ioc_allow,
   input logic [N_PINS-1:0] analog_sel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Pin outputs lag the register by one enabled edge
   sequence wr_s(logic [3:0] a);
      clk_en && wr_stb && addr == a ##1 clk_en;
   endsequence
   sel_low_a: assert property (wr_s(4'h0) |=> analog_sel[7:0] == $past(wdata, 2))
      else $error("low select");
   sel_high_a: assert property (wr_s(4'h1) |=>
      {4'h0, analog_sel[11:8]} == ($past(wdata, 2) & 8'h0F)) else $error("high select");
   high_zero_a: assert property (clk_en && rd_stb && addr == 4'h1 |=> rdata[7:4] == 4'h0)
      else $error("high bits");
   dir_drive_a: assert property (wr_s(4'h3) |=> pin_oe[7:0] == ~$past(wdata, 2))
      else $error("drive");
   digital_ioc_a: assert property (ioc_allow == ~analog_sel)
      else $error("change detect");
   analog_pull_a: assert property ((pullup_on & analog_sel) == '0)
      else $error("analog pull-up");
   out_pull_a: assert property ((pullup_on & pin_oe) == '0)
      else $error("output pull-up");
   analog_read_a: assert property (clk_en && rd_stb && addr == 4'h5 |=>
      (rdata & analog_sel[7:0]) == 8'h00) else $error("analog read");
endmodule
bind pas_top pas_chk #(.N_PINS(N_PINS)) i_pas_chk (.*);

// ==== test/pas_top_bench.sv ====
// Random and corner-case bench of the analog select block
module pas_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, rst_b = 0, wr_stb = 0, rd_stb = 0, clk_en = 1;
   logic [3:0]  addr = 0;
   logic [7:0]  wdata = 0, rdata, s, h, p, d, o;
   logic [11:0] pin_in = 0, pin_out, pin_oe, pullup_on, ioc_allow, analog_sel;
   int          err_count = 0, tests_run = 0, cyc = 0;
   pas_top i_pas_top (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_on(pullup_on), .ioc_allow(ioc_allow), .analog_sel(analog_sel));
   initial forever #5 clk = ~clk;
   function automatic logic [11:0] pull_exp(input logic [7:0] pe, dr, an);
      return {4'h0, pe & 8'h37 & dr & ~an};
   endfunction
   task automatic give_verdict();
      $display("errors %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [11:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'h1;
      @(posedge clk);
      wr_stb <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'h1;
      @(posedge clk);
      rd_stb <= 1'h0;
      #1 chk({4'h0, rdata}, {4'h0, e});
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         err_count++;
         give_verdict();
      end
   end
   initial
   begin
      void'($urandom(32'hA72D1E57));
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      rd(4'h0, 8'hFF);
      rd(4'h1, 8'h0F);
      rd(4'h2, 8'h37);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      for (int i = 0; i < 40; i++)
      begin
         {s, h, p, d, o} = 40'({$urandom, $urandom});
         // First passes: all digital with pins 0-7 driving, then all analog set as inputs
         if (i < 2)
            {s, h, d} = {{8{i[0]}}, 8'hF0 | {8{i[0]}}, {8{i[0]}}};
         @(posedge clk) pin_in <= 12'($urandom);
         wr(4'h0, s);
         wr(4'h1, h);
         wr(4'h2, p);
         wr(4'h3, d);
         wr(4'h4, o);
         rd(4'h1, {4'h0, h[3:0]});
         rd(4'h5, pin_in[7:0] & ~s);
         rd(4'h6, {4'h0, pin_in[11:8] & ~h[3:0]});
         chk(analog_sel, {h[3:0], s});
         chk(ioc_allow, ~{h[3:0], s});
         chk(pullup_on, pull_exp(p, d, s));
         chk(pin_oe, {4'h0, ~d});
         chk(pin_out, {4'h0, o});
      end
      // Frozen clock enable: writes ignored, read data held
      rd(4'h0, s);
      @(posedge clk) clk_en <= 1'h0;
      wr(4'h0, ~s);
      wr(4'h4, ~o);
      rd(4'h2, s);
      chk(analog_sel, {h[3:0], s});
      chk(pin_out, {4'h0, o});
      @(posedge clk) clk_en <= 1'h1;
      rd(4'h0, s);
      // Mid-run reset brings back the reset values
      @(posedge clk) rst_b <= 1'h0;
      repeat (2) @(posedge clk);
      rst_b <= 1'h1;
      #1 chk(analog_sel, 12'hFFF);
      chk(pullup_on, 12'h000);
      chk(pin_oe, 12'h000);
      rd(4'h0, 8'hFF);
      rd(4'h1, 8'h0F);
      rd(4'h2, 8'h37);
      give_verdict();
   end
endmodule
